// >>> hdl/pdc_pkg.sv
// constants of the power-down control block
package pdc_pkg;
	// =========================================================
	// clock
	localparam int CLK_PERIOD_NS     = 40;                // 25 MHz core clock
	// =========================================================
	// clock hold after entry: the larger of 5 ns and 5 clocks
	localparam int CLK_HOLD_NS       = 5;                 // time part
	localparam int CLK_HOLD_NCK      = 5;                 // clock count part
	localparam int CLK_HOLD_NS_CYC   = (CLK_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CLK_HOLD_CYC      = (CLK_HOLD_NS_CYC > CLK_HOLD_NCK) ?
	                                   CLK_HOLD_NS_CYC : CLK_HOLD_NCK;
	// =========================================================
	// exit to command delay (plain default, least time, rounded up)
	localparam int EXIT_DELAY_NS     = 10;
	localparam int EXIT_DELAY_RAW    = (EXIT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int EXIT_DELAY_CYC    = (EXIT_DELAY_RAW < 1) ? 1 : EXIT_DELAY_RAW;
	// =========================================================
	// termination configuration field, command-bus odt enable
	localparam int TERM_CFG_W        = 8;                 // config register width
	localparam int TERM_CA_ODT_LSB   = 4;                 // field low bit
	localparam int TERM_CA_ODT_MSB   = 6;                 // field high bit
	localparam logic [2:0] TERM_ODT_OFF = 3'h0;           // field value meaning off
	// =========================================================
	// command address bus width
	localparam int CA_W              = 6;
	// =========================================================
	// power-down flavour seen at entry
	typedef enum logic [1:0]
	{
		PD_NONE   = 2'h0,
		PD_IDLE   = 2'h1,
		PD_ACTIVE = 2'h2,
		PD_SELF   = 2'h3
	} pdc_kind_t;
	// =========================================================
	// control states
	typedef enum logic [1:0]
	{
		ST_RUN    = 2'h0,  // normal operation
		ST_HOLD   = 2'h1,  // clock hold after entry
		ST_DOWN   = 2'h2,  // receivers off
		ST_EXIT   = 2'h3   // exit latency running
	} pdc_state_t;
endpackage

// >>> hdl/pdc_power_down.sv
// power-down entry and exit control of one memory channel
`timescale 1ns/1ns
module pdc_power_down
#(
	parameter int CNT_W     = 8,                          // timer width
	parameter int HOLD_CYC  = pdc_pkg::CLK_HOLD_CYC,      // clock hold after entry
	parameter int EXIT_CYC  = pdc_pkg::EXIT_DELAY_CYC     // exit to command delay
)
(
	input  wire logic                          i_mclk,          // command clock
	input  wire logic                          i_nrst,          // sync reset, low active
	input  wire logic                          i_cke,           // clock_enable_input
	input  wire logic                          i_cs,            // chip_select_input
	input  wire logic [pdc_pkg::CA_W-1:0]      i_ca,            // command_address_bus
	input  wire logic                          i_row_open,      // any bank has a row open
	input  wire logic                          i_bank_busy,     // act/pre/refresh in flight
	input  wire logic                          i_self_refresh,  // self refresh running
	input  wire logic [pdc_pkg::TERM_CFG_W-1:0] i_term_cfg,     // termination_config_reg
	input  wire logic                          i_odt_override,  // override reg or pad enable
	output logic                               o_io_buf_en,     // io buffers enabled
	output logic                               o_rx_en,         // input receivers enabled
	output logic                               o_cmd_decode_en, // command decoder allowed
	output logic                               o_cmd_cs,        // select passed to decoder
	output logic [pdc_pkg::CA_W-1:0]           o_cmd_ca,        // bus passed to decoder
	output logic                               o_power_down,    // in power-down (hold/down)
	output logic [1:0]                         o_pd_kind,       // flavour at entry
	output logic                               o_low_current,   // reduced current reached
	output logic                               o_auto_refresh_allow, // refresh engine allowed
	output logic                               o_self_refresh_run,   // self refresh engine on
	output logic                               o_ca_odt_on      // command-bus termination on
);
	// =========================================================
	// elaboration checks
	if (HOLD_CYC < 1 || HOLD_CYC >= (1 << CNT_W))
	begin : g_bad_hold
		$error("pdc_power_down: hold count does not fit the timer");
	end
	if (EXIT_CYC < 1 || EXIT_CYC >= (1 << CNT_W))
	begin : g_bad_exit
		$error("pdc_power_down: exit count does not fit the timer");
	end

	localparam logic [CNT_W-1:0] HOLD_LOAD = CNT_W'(HOLD_CYC - 1);  // timer reload, hold
	localparam logic [CNT_W-1:0] EXIT_LOAD = CNT_W'(EXIT_CYC - 1);  // timer reload, exit

	// =========================================================
	// state
	pdc_pkg::pdc_state_t state;          // control state
	pdc_pkg::pdc_state_t next_state;     // next control state
	pdc_pkg::pdc_kind_t  kind;           // flavour captured at entry
	pdc_pkg::pdc_kind_t  next_kind;      // next flavour
	pdc_pkg::pdc_kind_t  kind_now;       // flavour if entry happened now
	logic                cmd_cs;         // registered select
	logic                next_cmd_cs;    // next select
	logic [pdc_pkg::CA_W-1:0] cmd_ca;    // registered bus
	logic [pdc_pkg::CA_W-1:0] next_cmd_ca; // next bus
	logic                tmr_load;       // timer load strobe
	logic [CNT_W-1:0]    tmr_value;      // timer load value
	logic                tmr_zero;       // timer expired
	logic                in_pd;          // hold or down state

	// =========================================================
	// timer for clock hold and exit latency
	pdc_timer #(.CNT_W(CNT_W)) u_timer
	(
		.i_mclk  (i_mclk),
		.i_nrst  (i_nrst),
		.i_load  (tmr_load),
		.i_count (tmr_value),
		.o_zero  (tmr_zero)
	);

	// =========================================================
	// flavour of a power-down that would start in this cycle
	// self refresh beats an open row, which beats idle
	always_comb
	begin
		if (i_self_refresh)
			kind_now = pdc_pkg::PD_SELF;
		else if (i_row_open)
			kind_now = pdc_pkg::PD_ACTIVE;
		else
			kind_now = pdc_pkg::PD_IDLE;
	end

	// =========================================================
	// control state machine, next values
	always_comb
	begin
		next_state = state;
		next_kind  = kind;
		tmr_load   = 1'b0;
		tmr_value  = HOLD_LOAD;
		case (state)
			pdc_pkg::ST_RUN:
			begin
				// entry: nothing waits for a command, no lockout here
				if (!i_cke)
				begin
					next_state = pdc_pkg::ST_HOLD;
					next_kind  = kind_now;
					tmr_load   = 1'b1;
				end
			end
			pdc_pkg::ST_HOLD:
			begin
				// clock still running, receivers kept alive
				if (i_cke)
				begin
					next_state = pdc_pkg::ST_EXIT;
					tmr_load   = 1'b1;
					tmr_value  = EXIT_LOAD;
				end
				else if (tmr_zero)
					next_state = pdc_pkg::ST_DOWN;
			end
			pdc_pkg::ST_DOWN:
			begin
				// only enable is watched; clock may be stopped here
				if (i_cke)
				begin
					next_state = pdc_pkg::ST_EXIT;
					tmr_load   = 1'b1;
					tmr_value  = EXIT_LOAD;
				end
			end
			pdc_pkg::ST_EXIT:
			begin
				// re-entry during exit restarts the clock hold
				if (!i_cke)
				begin
					next_state = pdc_pkg::ST_HOLD;
					next_kind  = kind_now;
					tmr_load   = 1'b1;
				end
				else if (tmr_zero)
				begin
					next_state = pdc_pkg::ST_RUN;
					next_kind  = pdc_pkg::PD_NONE;
				end
			end
			default:
			begin
				next_state = pdc_pkg::ST_RUN;
				next_kind  = pdc_pkg::PD_NONE;
			end
		endcase
	end

	// =========================================================
	// command path, next values
	// select and bus are dropped unless the decoder is allowed;
	// a low enable blocks them in the same cycle, before the fsm moves
	always_comb
	begin
		next_cmd_cs = i_cs && i_cke && (state == pdc_pkg::ST_RUN);
		next_cmd_ca = next_cmd_cs ? i_ca : '0;
	end

	// =========================================================
	// registers only
	always_ff @(posedge i_mclk)
	begin
		if (!i_nrst)
		begin
			state  <= pdc_pkg::ST_RUN;
			kind   <= pdc_pkg::PD_NONE;
			cmd_cs <= 1'b0;
			cmd_ca <= '0;
		end
		else
		begin
			state  <= next_state;
			kind   <= next_kind;
			cmd_cs <= next_cmd_cs;
			cmd_ca <= next_cmd_ca;
		end
	end

	// =========================================================
	// outputs
	assign in_pd = (state == pdc_pkg::ST_HOLD) || (state == pdc_pkg::ST_DOWN);

	// io buffers follow enable without a clock edge both ways and receivers
	// wake without one, since the clock may be gone while the channel sleeps
	assign o_io_buf_en     = i_cke;
	assign o_rx_en         = (state != pdc_pkg::ST_DOWN) || i_cke;
	assign o_cmd_decode_en = (state == pdc_pkg::ST_RUN);
	assign o_cmd_cs        = cmd_cs;
	assign o_cmd_ca        = cmd_ca;
	assign o_power_down    = in_pd;
	assign o_pd_kind       = kind;
	// pending row work still draws current until done
	assign o_low_current   = in_pd && !i_bank_busy;
	// only self refresh keeps refreshing; others rely on the controller
	assign o_auto_refresh_allow = !in_pd;
	assign o_self_refresh_run   = i_self_refresh &&
	                              (!in_pd || kind == pdc_pkg::PD_SELF);
	// termination ignores the power state entirely
	assign o_ca_odt_on = i_odt_override &&
		(i_term_cfg[pdc_pkg::TERM_CA_ODT_MSB:pdc_pkg::TERM_CA_ODT_LSB]
		 != pdc_pkg::TERM_ODT_OFF);

	// =========================================================
	// assertions
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_nrst);

	sequence s_entry;
		(state == pdc_pkg::ST_RUN) && !i_cke;
	endsequence

	sequence s_exit;
		(state == pdc_pkg::ST_DOWN) && i_cke;
	endsequence

	entry_moves_a: assert property (s_entry |=> state == pdc_pkg::ST_HOLD)
		else $error("entry did not move to hold");

	hold_rx_on_a: assert property (s_entry ##1 (!i_cke)[*4] |-> o_rx_en && state == pdc_pkg::ST_HOLD)
		else $error("receivers off before clock hold expired");

	hold_ends_a: assert property (s_entry ##1 (!i_cke)[*5] |=> state == pdc_pkg::ST_DOWN)
		else $error("clock hold did not end after five cycles");

	down_ignores_a: assert property (state == pdc_pkg::ST_DOWN && !i_cke |-> !o_rx_en ##1 !o_cmd_cs)
		else $error("inputs seen during power-down");

	kind_capture_a: assert property (s_entry |=> o_pd_kind == $past(kind_now))
		else $error("flavour not captured at entry");

	exit_blocks_a: assert property (s_exit |=> state == pdc_pkg::ST_EXIT && !o_cmd_decode_en)
		else $error("decoder allowed before exit delay");

	exit_done_a: assert property (state == pdc_pkg::ST_EXIT && i_cke && tmr_zero |=> o_cmd_decode_en)
		else $error("decoder not back after exit delay");

	cmd_gate_a: assert property (o_cmd_cs |-> $past(state == pdc_pkg::ST_RUN && i_cke))
		else $error("command passed while not running");

	low_current_a: assert property (in_pd && i_bank_busy |-> !o_low_current)
		else $error("low current claimed with work pending");

	refresh_stop_a: assert property (in_pd && o_pd_kind != pdc_pkg::PD_SELF |-> !o_auto_refresh_allow && !o_self_refresh_run)
		else $error("refresh running in plain power-down");

	self_ref_keep_a: assert property (in_pd && o_pd_kind == pdc_pkg::PD_SELF && i_self_refresh |-> o_self_refresh_run)
		else $error("self refresh stopped in its power-down");

	odt_keep_a: assert property (in_pd && i_odt_override &&
		i_term_cfg[pdc_pkg::TERM_CA_ODT_MSB:pdc_pkg::TERM_CA_ODT_LSB] != pdc_pkg::TERM_ODT_OFF
		|-> o_ca_odt_on)
		else $error("command termination dropped in power-down");
endmodule

// >>> hdl/pdc_timer.sv
// down counter used for the hold and exit periods
`timescale 1ns/1ns
module pdc_timer
#(
	parameter int CNT_W = 8  // counter width
)
(
	input  wire logic             i_mclk,   // core clock
	input  wire logic             i_nrst,   // synchronous reset, low active
	input  wire logic             i_load,   // load pulse
	input  wire logic [CNT_W-1:0] i_count,  // value loaded
	output logic                  o_zero    // count has run out
);
	// =========================================================
	// elaboration check
	if (CNT_W < 2)
	begin : g_bad_width
		$error("pdc_timer: counter width too small");
	end

	logic [CNT_W-1:0] cnt;       // current count
	logic [CNT_W-1:0] next_cnt;  // next count

	// =========================================================
	// next count: load wins, else count down to zero and stop
	always_comb
	begin
		if (i_load)
			next_cnt = i_count;
		else if (cnt != '0)
			next_cnt = cnt - {{(CNT_W-1){1'b0}}, 1'b1};
		else
			next_cnt = cnt;
	end

	// register only
	always_ff @(posedge i_mclk)
	begin
		if (!i_nrst)
			cnt <= '0;
		else
			cnt <= next_cnt;
	end

	assign o_zero = (cnt == '0);
endmodule

// >>> verification/pdc_ctrl_model.sv
// controller-side model driving clock enable, select and command bus
`timescale 1ns/1ns
module pdc_ctrl_model
#(
	parameter int HOLD_CYC = 5,  // clock hold after entry
	parameter int EXIT_CYC = 1,  // exit to command delay
	parameter int MIN_CKE  = 3,  // min enable pulse, plain default
	parameter int CMD_GAP  = 4   // command to entry delay, plain default
)
(
	input  wire logic                   i_mclk,  // command clock
	output logic                        o_cke,   // clock_enable_input
	output logic                        o_cs,    // chip_select_input
	output logic [pdc_pkg::CA_W-1:0]    o_ca     // command_address_bus
);
	// =========================================================
	// counters read right after an edge, so they hold pre-edge values
	int hi_cnt = 0;  // edges with enable high
	int lo_cnt = 0;  // edges with enable low
	int gap    = 0;  // edges since last select
	initial
	begin
		o_cke = 1'b1;
		o_cs  = 1'b0;
		o_ca  = '0;
	end
	// =========================================================
	// cycle counters
	always @(posedge i_mclk)
	begin
		hi_cnt <= o_cke ? hi_cnt + 1 : 0;
		lo_cnt <= o_cke ? 0 : lo_cnt + 1;
		gap    <= o_cs ? 0 : gap + 1;
	end
	// =========================================================
	// entry only after the command gap and a full high pulse
	task automatic enter();
		do @(posedge i_mclk); while (gap < CMD_GAP || hi_cnt < MIN_CKE);
		o_cke <= 1'b0;
		o_cs  <= 1'b0; // select stays low through the hold
	endtask
	// select chatter once the hold is over, inputs are don't care then
	task automatic noise();
		do @(posedge i_mclk); while (lo_cnt < HOLD_CYC);
		o_cs <= 1'b1;
		o_ca <= o_ca + 1'b1;
		@(posedge i_mclk);
		o_cs <= 1'b0;
		o_ca <= ~o_ca;
	endtask
	// exit after the low pulse has lasted long enough
	task automatic leave();
		do @(posedge i_mclk); while (lo_cnt < MIN_CKE);
		o_cke <= 1'b1;
	endtask
	// command; early skips the exit wait on purpose
	task automatic cmd(input logic [pdc_pkg::CA_W-1:0] ca, input logic early);
		do @(posedge i_mclk); while (!early && hi_cnt < EXIT_CYC);
		o_cs <= 1'b1;
		o_ca <= ca;
		@(posedge i_mclk);
		o_cs <= 1'b0;
		o_ca <= ~ca; // released bus does not keep its value
	endtask
endmodule

// >>> verification/pdc_power_down_test.sv
// self-checking bench of the power-down control block
`timescale 1ns/1ns
module pdc_power_down_test;
	localparam int HOLD = 5;  // clock hold cycles
	localparam int EXC  = 1;  // exit delay cycles
	logic                        i_mclk = 1'b0;  // command clock
	logic                        i_nrst = 1'b0;  // sync reset
	logic                        i_row_open = 1'b0;
	logic                        i_bank_busy = 1'b0;
	logic                        i_self_refresh = 1'b0;
	logic [7:0]                  i_term_cfg = 8'h00;
	logic                        i_odt_override = 1'b0;
	logic                        cke;
	logic                        cs;
	logic [pdc_pkg::CA_W-1:0]    ca;
	logic                        o_io_buf_en, o_rx_en, o_cmd_decode_en, o_cmd_cs;
	logic [pdc_pkg::CA_W-1:0]    o_cmd_ca;
	logic                        o_power_down, o_low_current, o_auto_refresh_allow;
	logic [1:0]                  o_pd_kind;
	logic                        o_self_refresh_run, o_ca_odt_on;
	int                          failures = 0;
	int                          num_checks = 0;
	int                          cycles = 0;
	// free-running clock, never changed or stopped
	always #20 i_mclk = ~i_mclk;
	pdc_ctrl_model #(.HOLD_CYC(HOLD), .EXIT_CYC(EXC)) u_m
	(.i_mclk(i_mclk), .o_cke(cke), .o_cs(cs), .o_ca(ca));
	pdc_power_down #(.CNT_W(8), .HOLD_CYC(HOLD), .EXIT_CYC(EXC)) u_dut
	(.i_mclk(i_mclk), .i_nrst(i_nrst), .i_cke(cke), .i_cs(cs), .i_ca(ca),
	 .i_row_open(i_row_open), .i_bank_busy(i_bank_busy), .i_self_refresh(i_self_refresh),
	 .i_term_cfg(i_term_cfg), .i_odt_override(i_odt_override), .o_io_buf_en(o_io_buf_en),
	 .o_rx_en(o_rx_en), .o_cmd_decode_en(o_cmd_decode_en), .o_cmd_cs(o_cmd_cs),
	 .o_cmd_ca(o_cmd_ca), .o_power_down(o_power_down), .o_pd_kind(o_pd_kind),
	 .o_low_current(o_low_current), .o_auto_refresh_allow(o_auto_refresh_allow),
	 .o_self_refresh_run(o_self_refresh_run), .o_ca_odt_on(o_ca_odt_on));
	// =========================================================
	// shared compare, case inequality so unknowns fail
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("wrong value %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	// one edge, then let its updates settle
	task automatic step();
		@(posedge i_mclk);
		#1;
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// =========================================================
	// hang guard, run needs about a hundred cycles
	always @(posedge i_mclk)
	begin
		cycles <= cycles + 1;
		if (cycles == 3000)
		begin
			failures++;
			end_of_test();
		end
	end
	// reset values, then one accepted command
	task automatic t_reset_cmd();
		repeat (10) step();
		check("decode_en", 1, o_cmd_decode_en);
		check("power_down", 0, o_power_down);
		check("pd_kind", 0, o_pd_kind);
		@(posedge i_mclk);
		i_nrst <= 1'b1;
		u_m.cmd(6'h2A, 1'b0);
		#1;
		check("cmd_cs", 1, o_cmd_cs);
		check("cmd_ca", 8'h2A, o_cmd_ca);
		step();
		check("cmd_cs idle", 0, o_cmd_cs);
	endtask
	// full entry, down, ignored select, exit and early command
	task automatic t_pd(input logic row, input logic slf, input logic busy, input logic [1:0] k);
		@(posedge i_mclk);
		i_row_open     <= row;
		i_self_refresh <= slf;
		i_bank_busy    <= busy;
		i_term_cfg     <= 8'h2F;
		i_odt_override <= 1'b1;
		u_m.enter();
		#1;
		check("io_buf_en entry", 0, o_io_buf_en);
		step();
		check("power_down", 1, o_power_down);
		check("pd_kind", k, o_pd_kind);
		check("refresh_allow", 0, o_auto_refresh_allow);
		check("self_run", slf, o_self_refresh_run);
		check("low_current busy", !busy, o_low_current);
		repeat (HOLD - 1) step();
		check("rx_en hold", 1, o_rx_en);
		step();
		check("rx_en down", 0, o_rx_en);
		check("ca_odt down", 1, o_ca_odt_on);
		check("decode_en down", 0, o_cmd_decode_en);
		@(posedge i_mclk);
		i_bank_busy <= 1'b0;
		#1;
		check("low_current", 1, o_low_current);
		u_m.noise();
		#1;
		check("cmd_cs down", 0, o_cmd_cs);
		check("cmd_ca down", 0, o_cmd_ca);
		u_m.leave();
		#1;
		check("io_buf_en exit", 1, o_io_buf_en);
		check("rx_en exit", 1, o_rx_en);
		u_m.cmd(6'h15, 1'b1);
		#1;
		check("cmd_cs exit", 0, o_cmd_cs);
		check("cmd_ca exit", 0, o_cmd_ca);
		check("decode_en run", 1, o_cmd_decode_en);
		check("refresh_allow run", 1, o_auto_refresh_allow);
		u_m.cmd(6'h33, 1'b0);
		#1;
		check("cmd_cs run", 1, o_cmd_cs);
		check("cmd_ca run", 8'h33, o_cmd_ca);
	endtask
	// exit while the clock hold still runs, then back to normal
	task automatic t_short();
		@(posedge i_mclk);
		i_row_open     <= 1'b0;
		i_self_refresh <= 1'b0;
		u_m.enter();
		step();
		check("pd_kind short", 1, o_pd_kind);
		u_m.leave();
		#1;
		check("power_down hold", 1, o_power_down);
		check("rx_en hold short", 1, o_rx_en);
		step();
		check("power_down exit", 0, o_power_down);
		check("decode_en exit", 0, o_cmd_decode_en);
		step();
		check("decode_en back", 1, o_cmd_decode_en);
		check("pd_kind back", 0, o_pd_kind);
	endtask
	// every field value with and without override, stray bits set
	task automatic t_odt();
		for (int v = 0; v < 16; v++)
		begin
			@(posedge i_mclk);
			i_term_cfg     <= {1'b1, 3'(v), 4'hF};
			i_odt_override <= v[3];
			#1;
			check("ca_odt", (v[3] && v[2:0] != 0), o_ca_odt_on);
		end
	endtask
	initial
	begin
		t_reset_cmd();
		t_pd(1'b0, 1'b0, 1'b0, 2'h1);
		t_pd(1'b1, 1'b0, 1'b1, 2'h2);
		t_pd(1'b1, 1'b1, 1'b0, 2'h3);
		t_short();
		t_odt();
		end_of_test();
	end
endmodule
